//--- rtl/rsd_pkg.sv
// package: constants and carrier types for the relay signal distribution block
package rsd_pkg;
    localparam int RELAYS_PER_DECODER = 7;
    localparam int DECODERS = 2;
    localparam int RELAY_COUNT = 14;
    localparam int WORD_WIDTH = 8;
    localparam int CLOCK_HZ = 40_000_000;
    localparam int SUPERVISION_S = 5;
    localparam longint SUPERVISION_CYCLES = longint'(SUPERVISION_S) * longint'(CLOCK_HZ);
    // instruction word fields
    localparam int FIELD_OPERATE_BIT = 7;
    localparam int FIELD_DECODER_BIT = 3;
    localparam int FIELD_POINT_LSB = 0;
    localparam int FIELD_POINT_WIDTH = 3;
    localparam logic [13:0] RELAY_RESET = 14'h0000;

    typedef struct packed {
        logic operate;
        logic [2:0] spare;
        logic decoder;
        logic [2:0] point;
    } rsd_instr_t;

    typedef enum logic [1:0] {
        RSD_SUP_IDLE = 2'b01,
        RSD_SUP_RUN = 2'b10
    } rsd_sup_state_t;
endpackage

//--- rtl/rsd_relay_distribution.sv
// module: two channel decoders driving fourteen relays with link supervision on relay 0
// Notes on behaviour
// - Fourteen relay circuits exist, each operated or released on its own by the host, relay 0 only when not supervised.
// - Each decoder governs seven relays, one distribution point per relay.
// - A relay other than supervised relay 0 changes only when its point is addressed and its decoder enable is high.
// - Decoder zero owns relays 0 to 6 and decoder one owns relays 7 to 13; none unused.
// - Each host word on the receive bus says whether the addressed relay operates or releases.
// - In the supervised variant, relay 0 is driven through the supervision timer only.
// - The supervision timer runs about five seconds and holds relay 0 operated while running.
// - Every heartbeat impulse retriggers the supervision timer.
// - When impulses stop and the timer expires, relay 0 is released.
`timescale 1ns/1ps
`default_nettype none
module rsd_relay_distribution #(
    parameter bit SUPERVISED = 1'b1,
    parameter longint SUPERVISION_CYCLES = rsd_pkg::SUPERVISION_CYCLES
) (
    input wire logic clock_i, // 40 MHz clock
    input wire logic reset_i, // synchronous, active high
    input wire logic [rsd_pkg::WORD_WIDTH-1:0] rx_data_i, // receive data bus word
    input wire logic [rsd_pkg::DECODERS-1:0] decoder_enable_i, // per-decoder channel enable
    input wire logic heartbeat_i, // office alarm unit impulse level
    output logic [rsd_pkg::RELAY_COUNT-1:0] relay_o, // relay drive, bit 0-6 dec0, 7-13 dec1
    output logic supervision_running_o // supervision timer running
);
    // the shelf enable selects our channel slot, so the word is taken only while enabled

    // ------------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------------

    rsd_pkg::rsd_instr_t instr;
    wire instr_operate;
    wire instr_decoder;
    wire [2:0] instr_point;
    wire point_valid;

    assign instr = rsd_pkg::rsd_instr_t'(rx_data_i);

    assign instr_operate = instr.operate;

    assign instr_decoder = instr.decoder;

    assign instr_point = instr.point;

    // point 7 would name an eighth relay on decoder zero or relay 14, neither of which is fitted
    assign point_valid = (instr_point != 3'h7);

    // ------------------------------------------------------------------
    // per-decoder acceptance
    // ------------------------------------------------------------------

    wire [rsd_pkg::DECODERS-1:0] decoder_take;

    genvar d;
    generate
        for (d = 0; d < rsd_pkg::DECODERS; d++) begin : g_decoder
            localparam logic DEC_SEL = 1'(d);
            wire selected;

            assign selected = (instr_decoder == DEC_SEL);

            // enable and select must coincide, or the word belongs to someone else
            assign decoder_take[d] = decoder_enable_i[d] && selected && point_valid;
        end
    endgenerate

    // ------------------------------------------------------------------
    // per-relay latch decode
    // ------------------------------------------------------------------

    logic [rsd_pkg::RELAY_COUNT-1:0] latch_state;
    wire [rsd_pkg::RELAY_COUNT-1:0] relay_hit;
    wire [rsd_pkg::RELAY_COUNT-1:0] next_latch;

    genvar g;
    generate
        for (g = 0; g < rsd_pkg::RELAY_COUNT; g++) begin : g_relay
            localparam int DEC = g / rsd_pkg::RELAYS_PER_DECODER;
            localparam int PT = g % rsd_pkg::RELAYS_PER_DECODER;
            localparam logic [2:0] PT_CODE = 3'(PT);
            wire point_match;

            assign point_match = (instr_point == PT_CODE);

            assign relay_hit[g] = decoder_take[DEC] && point_match;

            // an unaddressed relay keeps its state
            assign next_latch[g] = relay_hit[g] ? instr_operate : latch_state[g];
        end
    endgenerate

    // ------------------------------------------------------------------
    // heartbeat impulse detection
    // ------------------------------------------------------------------

    logic heartbeat_prev;
    wire heartbeat_edge;

    // only a rising edge counts, so a stuck-high line cannot keep the timer alive
    assign heartbeat_edge = heartbeat_i && !heartbeat_prev;

    // ------------------------------------------------------------------
    // supervision timer
    // ------------------------------------------------------------------

    localparam logic [31:0] SUP_LOAD = 32'(SUPERVISION_CYCLES - 1);

    rsd_pkg::rsd_sup_state_t sup_state;
    rsd_pkg::rsd_sup_state_t next_sup_state;
    logic [31:0] sup_count;
    logic [31:0] next_sup_count;
    wire timer_expired;

    assign timer_expired = (sup_count == 32'h00000000);

    always_comb begin
        next_sup_state = sup_state;
        next_sup_count = sup_count;
        case (sup_state)
            rsd_pkg::RSD_SUP_IDLE: begin
                if (heartbeat_edge) begin
                    next_sup_state = rsd_pkg::RSD_SUP_RUN;
                    next_sup_count = SUP_LOAD;
                end
            end
            rsd_pkg::RSD_SUP_RUN: begin
                if (heartbeat_edge) begin
                    // reload, not extend: release stays one period after the last impulse
                    next_sup_count = SUP_LOAD;
                end else if (timer_expired) begin
                    next_sup_state = rsd_pkg::RSD_SUP_IDLE;
                end else begin
                    next_sup_count = sup_count - 32'h00000001;
                end
            end
            default: begin
                next_sup_state = rsd_pkg::RSD_SUP_IDLE;
                next_sup_count = 32'h00000000;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------------

    wire next_running;
    wire next_relay0;
    wire [rsd_pkg::RELAY_COUNT-1:0] next_relay;

    assign next_running = (next_sup_state == rsd_pkg::RSD_SUP_RUN);

    // relay 0 follows the timer, not the decoder, when supervised
    assign next_relay0 = SUPERVISED ? next_running : next_latch[0];

    assign next_relay = {next_latch[rsd_pkg::RELAY_COUNT-1:1], next_relay0};

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            latch_state <= rsd_pkg::RELAY_RESET;
        end else begin
            latch_state <= next_latch;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            heartbeat_prev <= 1'b0;
        end else begin
            heartbeat_prev <= heartbeat_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sup_state <= rsd_pkg::RSD_SUP_IDLE;
            sup_count <= 32'h00000000;
        end else begin
            sup_state <= next_sup_state;
            sup_count <= next_sup_count;
        end
    end

    // outputs come straight from flops so the relay drivers see no decode glitches
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            relay_o <= rsd_pkg::RELAY_RESET;
            supervision_running_o <= 1'b0;
        end else begin
            relay_o <= next_relay;
            supervision_running_o <= next_running;
        end
    end
endmodule
`default_nettype wire

//--- sim/rsd_relay_distribution_assertions.sv
// checker: port assertions for the relay distribution block
`timescale 1ns/1ps
`default_nettype none
module rsd_chk #(parameter longint SUPERVISION_CYCLES = 20, parameter bit SUPERVISED = 1'b1) (
    input wire logic clock_i, reset_i,
    heartbeat_i, supervision_running_o, input wire logic [7:0] rx_data_i,
    input wire logic [1:0] decoder_enable_i, input wire logic [13:0] relay_o);
    int cnt;
    logic armed;
    // cycles since the last impulse was seen; armed stays low until the first one
    always_ff @(posedge clock_i) begin
        armed <= !reset_i && (armed || $rose(heartbeat_i));
        cnt <= ($rose(heartbeat_i) || reset_i) ? 0 : cnt + 1;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_take_dec_one: assert property (decoder_enable_i[1] && rx_data_i[3] && rx_data_i[2:0] != 3'h7
        |=> relay_o[7 + $past(rx_data_i[2:0])] == $past(rx_data_i[7])) else $error("decoder one relay");
    a_take_dec_zero: assert property (decoder_enable_i[0] && !rx_data_i[3] && rx_data_i[2:0] inside {[3'h1:3'h6]}
        |=> relay_o[$past(rx_data_i[2:0])] == $past(rx_data_i[7])) else $error("decoder zero relay");
    a_no_take: assert property (!(decoder_enable_i[rx_data_i[3]] && rx_data_i[2:0] != 3'h7)
        |=> $stable(relay_o[13:1])) else $error("relay moved without instruction");
    a_relay0_sup: assert property (!SUPERVISED || relay_o[0] == supervision_running_o)
        else $error("relay 0 off timer");
    a_timer_len: assert property (supervision_running_o == (armed && cnt < SUPERVISION_CYCLES))
        else $error("timer span");
    a_hb_start: assert property ($rose(heartbeat_i) |=> supervision_running_o ##1 (relay_o[0] || !SUPERVISED))
        else $error("no retrigger");
    a_timer_drop: assert property ($fell(supervision_running_o) |-> cnt == SUPERVISION_CYCLES)
        else $error("late drop");
    a_reset_clear: assert property (@(posedge clock_i) disable iff (1'b0) reset_i
        |=> relay_o == 14'h0000 && !supervision_running_o) else $error("reset state");
    cover property ($fell(supervision_running_o));
    cover property (decoder_enable_i[1] && rx_data_i[3] && rx_data_i[7]);
    cover property ($rose(heartbeat_i) && supervision_running_o);
endmodule
bind rsd_relay_distribution rsd_chk #(
    .SUPERVISION_CYCLES(SUPERVISION_CYCLES),
    .SUPERVISED(SUPERVISED)
) i_chk (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .heartbeat_i(heartbeat_i),
    .supervision_running_o(supervision_running_o),
    .rx_data_i(rx_data_i),
    .decoder_enable_i(decoder_enable_i),
    .relay_o(relay_o)
);
`default_nettype wire

//--- sim/rsd_shelf_model.sv
// model: shelf controller and alarm unit driving the block inputs
`timescale 1ns/1ps
`default_nettype none
module rsd_shelf_model (input wire logic clock_i, // block clock
    output logic [7:0] rx_data_o, output logic [1:0] enable_o, output logic heartbeat_o); // far side
    initial {rx_data_o, enable_o, heartbeat_o} = 11'h000;
    // a released bus shows the inverse word so a stale copy cannot pass
    task automatic put(input logic [7:0] w, input logic [1:0] e);
        @(posedge clock_i) #2 {rx_data_o, enable_o} = {e == 2'h0 ? ~w : w, e};
    endtask
    task automatic beat(input logic v);
        @(posedge clock_i) #2 heartbeat_o = v;
    endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// testbench: relay decoding and link supervision scenarios
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
    localparam longint S = 20;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] rx_data_i;
    logic [1:0] decoder_enable_i;
    logic heartbeat_i, supervision_running_o;
    logic [13:0] relay_o;
    logic [13:0] relay_plain;
    logic running_plain;
    int errors = 0, comparisons = 0, n;
    initial forever #12.5 clock_i = ~clock_i;
    rsd_relay_distribution #(.SUPERVISION_CYCLES(S)) i_dut (.clock_i(clock_i), .reset_i(reset_i),
        .rx_data_i(rx_data_i), .decoder_enable_i(decoder_enable_i), .heartbeat_i(heartbeat_i),
        .relay_o(relay_o), .supervision_running_o(supervision_running_o));
    // plain variant: relay 0 follows its decoder directly
    rsd_relay_distribution #(.SUPERVISED(1'b0), .SUPERVISION_CYCLES(S)) i_dut_plain (
        .clock_i(clock_i), .reset_i(reset_i), .rx_data_i(rx_data_i),
        .decoder_enable_i(decoder_enable_i), .heartbeat_i(heartbeat_i),
        .relay_o(relay_plain), .supervision_running_o(running_plain));
    rsd_shelf_model i_shelf (.clock_i(clock_i), .rx_data_o(rx_data_i), .enable_o(decoder_enable_i),
        .heartbeat_o(heartbeat_i));
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_decode(); // every point back to back, then a misaddressed word
        for (int op = 1; op >= 0; op--) begin
            for (n = 0; n < 16; n++) i_shelf.put({op[0], 3'h0, n[3:0]}, 2'h3);
            i_shelf.put({~op[0], 7'h0B}, 2'h1);
            i_shelf.put(8'h00, 2'h0);
            `CHK("relay_o", op[0] ? 14'h3FFE : 14'h0000, relay_o)
            `CHK("relay plain", op[0] ? 14'h3FFF : 14'h0000, relay_plain)
        end
        $display("test decode done");
    endtask
    task automatic t_super(); // retrigger mid-run, then let the timer lapse
        i_shelf.beat(1'b1);
        i_shelf.beat(1'b0);
        `CHK("running", 1'b1, supervision_running_o)
        repeat (10) @(posedge clock_i);
        i_shelf.beat(1'b1);
        i_shelf.put(8'h00, 2'h1);
        for (n = 0; n < 100 && supervision_running_o === 1'b1; n++) @(posedge clock_i) #2;
        `CHK("hold cycles", S, longint'(n))
        `CHK("relay 0", 1'b0, relay_o[0])
        `CHK("plain relay 0", 1'b0, relay_plain[0])
        `CHK("plain running", 1'b0, running_plain)
        i_shelf.beat(1'b0);
        $display("test supervision done");
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        #2 reset_i = 1'b0;
        `CHK("reset state", 15'h0000, {relay_o, supervision_running_o})
        t_decode();
        t_super();
        final_report();
    end
    initial begin
        repeat (400) @(posedge clock_i);
        errors++;
        final_report();
    end
endmodule
`default_nettype wire
